// ==== design/afps_pkg.sv ====
// Constants, types and register map of the power mode sequencer
// Overview of operation
// - Regenerate sample clock falling edge, 50% duty
// - Stabilizer relocks after eight equal clock periods
// - Power-down pin high enters power-down state
// - Serial outputs high impedance during power-down
// - Power-down pin low resumes normal operation
// - Standby keeps only references, outputs high impedance
// - Standby pin low resumes normal operation
// - Power-down shuts reference, buffer, PLL, bias
// - Serial port powers down channels or enters standby
// - Serial standby may keep the PLL powered
// - Channels start at start count, stop at stop
// - Start and stop counted from transmit trigger
// - Analog powers up ahead by programmable advance
// - Serial output uses one, two or four lanes
// - Preamp bias selectable, resets to mid-high level
// - Samples taken on sample clock rising edge
package afps_pkg;
	localparam logic [12:0] ADDR_PWR_CTRL    = 13'h0008;
	localparam logic [12:0] ADDR_CH_FULL_POWERDOWN_PIN     = 13'h0009;
	localparam logic [12:0] ADDR_PREAMP_BIAS = 13'h0012;
	localparam logic [12:0] ADDR_ADVANCE     = 13'h0112;
	localparam logic [12:0] ADDR_START       = 13'h0113;
	localparam logic [12:0] ADDR_STOP        = 13'h0114;
	localparam logic [12:0] ADDR_LANES       = 13'h0115;
	localparam logic [12:0] ADDR_STATUS      = 13'h0116;

	localparam logic [7:0] PWR_CTRL_RST    = 8'h04;
	localparam logic [7:0] CH_FULL_POWERDOWN_PIN_RST     = 8'h00;
	localparam logic [7:0] PREAMP_BIAS_RST = 8'h02;
	localparam logic [7:0] ADVANCE_RST     = 8'h00;
	localparam logic [7:0] START_RST       = 8'h00;
	localparam logic [7:0] STOP_RST        = 8'hff;
	localparam logic [7:0] LANES_RST       = 8'h02;

	localparam int PWR_STANDBY_PIN_BIT     = 0;
	localparam int PWR_KEEP_PLL_BIT = 1;
	localparam int PWR_DCS_EN_BIT   = 2;

	localparam int CLK_HZ          = 50_000_000;
	localparam int US_CYCLES       = (CLK_HZ + 999_999) / 1_000_000;
	localparam int WAKE_TIME_US    = 375;
	localparam int DCS_LOCK_CYCLES = 8;
	localparam int SPI_INSTR_BITS  = 16;
	localparam int SPI_FRAME_BITS  = 24;

	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_PWRDN  = 2'b01,
		ST_STANDBY_PIN   = 2'b10,
		ST_WAKE   = 2'b11
	} afps_state_e;

	typedef struct packed {
		logic        wr;
		logic [12:0] addr;
		logic [7:0]  wdata;
	} afps_reg_req_s;

	typedef struct packed {
		logic ref_en;
		logic refbuf_en;
		logic pll_en;
		logic bias_en;
	} afps_supply_s;
endpackage

// ==== design/afps_spi.sv ====
// Serial control port slave: 16-bit instruction then one data byte
`timescale 1ns/10ps
module afps_spi (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	// Serial pins
	input  wire logic                    sclk_i,
	input  wire logic                    csb_n_i,
	input  wire logic                    sdio_i,
	output logic                         sdio_o,
	output logic                         sdio_oe_o,
	// Register side
	output afps_pkg::afps_reg_req_s      req_o,
	input  wire logic [7:0]              rdata_i
);
	import afps_pkg::*;

	typedef struct packed {
		logic          sk_m, sk_s, sk_p;
		logic          cs_m, cs_s;
		logic          di_m, di_s;
		logic [4:0]    bits;
		logic [15:0]   sh;
		logic          rd;
		logic          ld;
		logic [7:0]    rsh;
		logic          oe;
		logic          dout;
		afps_reg_req_s req;
	} afps_spi_s;

	afps_spi_s q, d;
	logic [15:0] nsh;

	always_comb begin
		d = q;
		d.sk_m = sclk_i;
		d.sk_s = q.sk_m;
		d.sk_p = q.sk_s;
		d.cs_m = csb_n_i;
		d.cs_s = q.cs_m;
		d.di_m = sdio_i;
		d.di_s = q.di_m;
		d.req.wr = 1'b0;
		nsh = {q.sh[14:0], q.di_s};
		if (q.ld) begin
			d.rsh = rdata_i;
			d.ld = 1'b0;
		end
		if (q.cs_s) begin
			d.bits = 5'h00;
			d.oe = 1'b0;
			d.rd = 1'b0;
		end else if (q.sk_s && !q.sk_p && q.bits < 5'(SPI_FRAME_BITS)) begin
			d.sh = nsh;
			d.bits = q.bits + 5'h01;
			if (q.bits == 5'(SPI_INSTR_BITS - 1)) begin
				d.rd = nsh[15];
				d.req.addr = nsh[12:0];
				d.ld = 1'b1;
			end
			if (q.bits == 5'(SPI_FRAME_BITS - 1) && !q.rd) begin
				d.req.wr = 1'b1;
				d.req.wdata = nsh[7:0];
			end
		end else if (!q.sk_s && q.sk_p && q.rd && q.bits >= 5'(SPI_INSTR_BITS)
				&& q.bits < 5'(SPI_FRAME_BITS)) begin
			// Read data leaves on falling edges so the master samples it on rising ones
			d.oe = 1'b1;
			d.dout = q.rsh[7];
			d.rsh = {q.rsh[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.sk_m <= 1'b0;
			q.cs_m <= 1'b1;
			q.cs_s <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign sdio_o = q.dout;
	assign sdio_oe_o = q.oe;
	assign req_o = q.req;
endmodule // afps_spi

// ==== design/afps_dcs.sv ====
// Duty-cycle stabilizer: rebuilds the falling edge from the measured period
`timescale 1ns/10ps
module afps_dcs (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Sample clock pin and control
	input  wire logic smp_clk_i,
	input  wire logic enable_i,
	// Results
	output logic      dcs_clk_o,
	output logic      sample_tick_o,
	output logic      lock_o
);
	import afps_pkg::*;

	typedef struct packed {
		logic       m, s, p;
		logic [7:0] per_cnt;
		logic [7:0] period;
		logic [3:0] lock_cnt;
		logic       clk;
		logic       tick;
		logic       lock;
	} afps_dcs_s;

	afps_dcs_s q, d;
	logic rise;

	always_comb begin
		d = q;
		d.m = smp_clk_i;
		d.s = q.m;
		d.p = q.s;
		rise = q.s && !q.p;
		d.tick = rise;
		if (rise) begin
			d.per_cnt = 8'h01;
			d.clk = 1'b1;
			if (q.per_cnt == q.period) begin
				if (q.lock_cnt != 4'(DCS_LOCK_CYCLES))
					d.lock_cnt = q.lock_cnt + 4'h1;
			end else begin
				d.lock_cnt = 4'h0;
				d.period = q.per_cnt;
			end
		end else begin
			if (q.per_cnt != 8'hff)
				d.per_cnt = q.per_cnt + 8'h01;
			if (!enable_i)
				d.clk = q.s;
			else if (q.per_cnt == {1'b0, q.period[7:1]})
				d.clk = 1'b0;
		end
		d.lock = (d.lock_cnt == 4'(DCS_LOCK_CYCLES)) || !enable_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= d;
	end

	assign dcs_clk_o = q.clk;
	assign sample_tick_o = q.tick;
	assign lock_o = q.lock;
endmodule // afps_dcs

// ==== design/afps_top.sv ====
// Power mode sequencer of the eight-channel receive front end
`timescale 1ns/10ps
module afps_top (
	// Clock and reset
	input  wire logic                  CLK_I,
	input  wire logic                  RST_N_I,
	// Power, trigger and sample clock pins
	input  wire logic                  FULL_POWERDOWN_PIN_I,
	input  wire logic                  STANDBY_PIN_I,
	input  wire logic                  TRANSMIT_TRIGGER_I,
	input  wire logic                  SAMPLE_CLK_I,
	// Serial control port
	input  wire logic                  SPI_SCLK_I,
	input  wire logic                  SPI_CSB_N_I,
	input  wire logic                  SPI_SDIO_I,
	output logic                       SPI_SDIO_O,
	output logic                       SPI_SDIO_OE_O,
	// Power controls
	output afps_pkg::afps_supply_s     SUPPLY_O,
	output logic [7:0]                 CH_ANALOG_EN_O,
	output logic [7:0]                 CH_DIGITAL_EN_O,
	output logic [3:0]                 LANE_OE_O,
	output logic [1:0]                 PREAMP_BIAS_O,
	// Clock stabilizer and status
	output logic                       DCS_CLK_O,
	output logic                       DCS_LOCK_O,
	output logic                       READY_O
);
	import afps_pkg::*;

	typedef struct packed {
		afps_state_e  st;
		logic         pd_m, pd_s;
		logic         sb_m, sb_s;
		logic         tg_m, tg_s, tg_p;
		logic [5:0]   us_div;
		logic [8:0]   pd_us;
		logic [8:0]   wake_cnt;
		logic [15:0]  cnt;
		logic         armed;
		logic [7:0]   pwr_ctrl;
		logic [7:0]   ch_full_powerdown_pin;
		logic [7:0]   bias;
		logic [7:0]   adv;
		logic [7:0]   start;
		logic [7:0]   stop;
		logic [7:0]   lanes;
		afps_supply_s sup;
		logic [7:0]   ana;
		logic [7:0]   dig;
		logic [3:0]   lane_oe;
		logic         ready;
	} afps_top_s;

	afps_top_s     q, d;
	afps_reg_req_s req;
	logic [7:0]    rdata;
	logic          sample_tick;
	logic          dcs_lock;
	logic          us_tick;
	logic          pd;
	logic          sb;
	logic          spi_standby_pin;
	logic [16:0]   ahead;
	logic          ana_win;
	logic          dig_win;
	logic          run;

	function automatic logic [3:0] lane_mask(input logic [7:0] code);
		unique case (code[1:0])
			2'b00:   lane_mask = 4'h1;
			2'b01:   lane_mask = 4'h3;
			default: lane_mask = 4'hf;
		endcase
	endfunction

	afps_spi u_spi (
		.clk_i     (CLK_I),
		.rst_n_i   (RST_N_I),
		.sclk_i    (SPI_SCLK_I),
		.csb_n_i   (SPI_CSB_N_I),
		.sdio_i    (SPI_SDIO_I),
		.sdio_o    (SPI_SDIO_O),
		.sdio_oe_o (SPI_SDIO_OE_O),
		.req_o     (req),
		.rdata_i   (rdata)
	);

	afps_dcs u_dcs (
		.clk_i         (CLK_I),
		.rst_n_i       (RST_N_I),
		.smp_clk_i     (SAMPLE_CLK_I),
		.enable_i      (q.pwr_ctrl[PWR_DCS_EN_BIT]),
		.dcs_clk_o     (DCS_CLK_O),
		.sample_tick_o (sample_tick),
		.lock_o        (dcs_lock)
	);

	always_comb begin
		rdata = 8'h00;
		unique case (req.addr)
			ADDR_PWR_CTRL:    rdata = q.pwr_ctrl;
			ADDR_CH_FULL_POWERDOWN_PIN:     rdata = q.ch_full_powerdown_pin;
			ADDR_PREAMP_BIAS: rdata = q.bias;
			ADDR_ADVANCE:     rdata = q.adv;
			ADDR_START:       rdata = q.start;
			ADDR_STOP:        rdata = q.stop;
			ADDR_LANES:       rdata = q.lanes;
			ADDR_STATUS:      rdata = {q.armed, q.ready, dcs_lock, 3'b000, q.st};
			default:          rdata = 8'h00;
		endcase
	end

	always_comb begin
		d = q;
		d.pd_m = FULL_POWERDOWN_PIN_I;
		d.pd_s = q.pd_m;
		d.sb_m = STANDBY_PIN_I;
		d.sb_s = q.sb_m;
		d.tg_m = TRANSMIT_TRIGGER_I;
		d.tg_s = q.tg_m;
		d.tg_p = q.tg_s;

		us_tick = (q.us_div == 6'(US_CYCLES - 1));
		d.us_div = us_tick ? 6'h00 : q.us_div + 6'h01;

		if (req.wr) begin
			unique case (req.addr)
				ADDR_PWR_CTRL:    d.pwr_ctrl = req.wdata;
				ADDR_CH_FULL_POWERDOWN_PIN:     d.ch_full_powerdown_pin = req.wdata;
				ADDR_PREAMP_BIAS: d.bias = req.wdata;
				ADDR_ADVANCE:     d.adv = req.wdata;
				ADDR_START:       d.start = req.wdata;
				ADDR_STOP:        d.stop = req.wdata;
				ADDR_LANES:       d.lanes = req.wdata;
				default:          d.bias = q.bias;
			endcase
		end

		pd = q.pd_s;
		spi_standby_pin = q.pwr_ctrl[PWR_STANDBY_PIN_BIT];
		sb = q.sb_s || spi_standby_pin;

		unique case (q.st)
			ST_NORMAL: begin
				if (pd) begin
					d.st = ST_PWRDN;
					d.pd_us = 9'h000;
				end else if (sb) begin
					d.st = ST_STANDBY_PIN;
				end
			end
			ST_STANDBY_PIN: begin
				if (pd) begin
					d.st = ST_PWRDN;
					d.pd_us = 9'h000;
				end else if (!sb) begin
					d.st = ST_NORMAL;
				end
			end
			ST_PWRDN: begin
				if (us_tick && q.pd_us != 9'(WAKE_TIME_US))
					d.pd_us = q.pd_us + 9'h001;
				if (!pd) begin
					d.st = ST_WAKE;
					d.wake_cnt = q.pd_us;
				end
			end
			ST_WAKE: begin
				// wake time follows time spent down
				if (pd) begin
					d.st = ST_PWRDN;
					d.pd_us = 9'h000;
				end else if (q.wake_cnt == 9'h000) begin
					d.st = sb ? ST_STANDBY_PIN : ST_NORMAL;
				end else if (us_tick) begin
					d.wake_cnt = q.wake_cnt - 9'h001;
				end
			end
		endcase

		d.sup.ref_en = (d.st != ST_PWRDN);
		d.sup.refbuf_en = (d.st != ST_PWRDN);
		d.sup.bias_en = (d.st == ST_NORMAL) || (d.st == ST_WAKE);
		d.sup.pll_en = d.sup.bias_en
			|| (d.st == ST_STANDBY_PIN && spi_standby_pin && !q.sb_s && q.pwr_ctrl[PWR_KEEP_PLL_BIT]);

		if (q.tg_s && !q.tg_p) begin
			d.cnt = 16'h0000;
			d.armed = 1'b1;
		end else if (sample_tick && q.armed && q.cnt != 16'hffff) begin
			d.cnt = q.cnt + 16'h0001;
		end

		ahead = {1'b0, q.cnt} + {9'h000, q.adv};
		dig_win = q.armed && (q.cnt >= {8'h00, q.start}) && (q.cnt < {8'h00, q.stop});
		ana_win = q.armed && (ahead >= {9'h000, q.start}) && (q.cnt < {8'h00, q.stop});
		run = (q.st == ST_NORMAL);
		d.ana = (run && ana_win) ? ~q.ch_full_powerdown_pin : 8'h00;
		d.dig = (run && dig_win) ? ~q.ch_full_powerdown_pin : 8'h00;

		// drivers high impedance when not running
		d.lane_oe = (d.st == ST_NORMAL) ? lane_mask(q.lanes) : 4'h0;
		d.ready = (d.st == ST_NORMAL) && dcs_lock;
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			q <= '0;
			q.st <= ST_NORMAL;
			q.pwr_ctrl <= PWR_CTRL_RST;
			q.ch_full_powerdown_pin <= CH_FULL_POWERDOWN_PIN_RST;
			q.bias <= PREAMP_BIAS_RST;
			q.adv <= ADVANCE_RST;
			q.start <= START_RST;
			q.stop <= STOP_RST;
			q.lanes <= LANES_RST;
		end else begin
			q <= d;
		end
	end

	assign SUPPLY_O = q.sup;
	assign CH_ANALOG_EN_O = q.ana;
	assign CH_DIGITAL_EN_O = q.dig;
	assign LANE_OE_O = q.lane_oe;
	assign PREAMP_BIAS_O = q.bias[1:0];
	assign DCS_LOCK_O = dcs_lock;
	assign READY_O = q.ready;
endmodule // afps_top

// ==== tb/afps_ctrl_model.sv ====
// Controller model driving the power, trigger and sample clock pins
`timescale 1ns/10ps
module afps_ctrl_model (
	// Clock and bench requests
	input  wire logic clk_i,
	input  wire logic pd_i,
	input  wire logic sb_i,
	input  wire logic tg_i,
	// Device pins
	output logic      pd_o = 1'b0,
	output logic      sb_o = 1'b0,
	output logic      tg_o = 1'b0,
	output logic      smp_o = 1'b0
);
	logic [2:0] ph = 3'h0;
	// high two cycles of eight, so a clock that is only passed through shows
	always @(posedge clk_i) begin
		ph <= ph + 3'h1;
		smp_o <= (ph[2:1] == 2'b11);
		pd_o <= pd_i;
		sb_o <= sb_i;
		tg_o <= tg_i;
	end
endmodule // afps_ctrl_model

// ==== tb/afps_assertions.sv ====
// Port checks of the power mode sequencer
`timescale 1ns/10ps
module afps_assertions (
	// Observed ports
	input wire logic                   CLK_I,
	input wire logic                   RST_N_I,
	input wire logic                   FULL_POWERDOWN_PIN_I,
	input wire logic                   STANDBY_PIN_I,
	input wire logic                   SPI_CSB_N_I,
	input wire logic                   SPI_SDIO_OE_O,
	input wire afps_pkg::afps_supply_s SUPPLY_O,
	input wire logic [7:0]             CH_ANALOG_EN_O,
	input wire logic [7:0]             CH_DIGITAL_EN_O,
	input wire logic [3:0]             LANE_OE_O,
	input wire logic                   READY_O
);
	import afps_pkg::*;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// Six cycles cover the pin synchronizer, state and output registers
	sequence pd_held;
		FULL_POWERDOWN_PIN_I [*6];
	endsequence
	sequence sb_held;
		STANDBY_PIN_I [*6];
	endsequence
	sequence cs_idle;
		SPI_CSB_N_I [*5];
	endsequence
	pd_supply_a: assert property (pd_held |-> SUPPLY_O == 4'h0)
		else $error("supply on in power-down");
	pd_lanes_a: assert property (pd_held |-> LANE_OE_O == 4'h0)
		else $error("lanes driven in power-down");
	pd_channels_a: assert property (pd_held |-> CH_ANALOG_EN_O == 8'h00 && CH_DIGITAL_EN_O == 8'h00)
		else $error("channel on in power-down");
	pd_ready_a: assert property (pd_held |-> !READY_O)
		else $error("ready in power-down");
	sb_lanes_a: assert property (sb_held |-> LANE_OE_O == 4'h0)
		else $error("lanes driven in standby");
	ready_power_a: assert property (READY_O |-> SUPPLY_O == 4'hf && LANE_OE_O != 4'h0)
		else $error("ready without full power");
	analog_lead_a: assert property ((CH_DIGITAL_EN_O & ~CH_ANALOG_EN_O) == 8'h00)
		else $error("digital run without analog power");
	oe_release_a: assert property (cs_idle |-> !SPI_SDIO_OE_O)
		else $error("data line driven while deselected");
endmodule // afps_assertions

bind afps_top afps_assertions i_afps_assertions (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
	.FULL_POWERDOWN_PIN_I(FULL_POWERDOWN_PIN_I), .STANDBY_PIN_I(STANDBY_PIN_I), .SPI_CSB_N_I(SPI_CSB_N_I),
	.SPI_SDIO_OE_O(SPI_SDIO_OE_O), .SUPPLY_O(SUPPLY_O), .CH_ANALOG_EN_O(CH_ANALOG_EN_O),
	.CH_DIGITAL_EN_O(CH_DIGITAL_EN_O), .LANE_OE_O(LANE_OE_O), .READY_O(READY_O));

// ==== tb/test_afps_top.sv ====
// Self-checking bench of the power mode sequencer
`timescale 1ns/10ps
module test_afps_top;
	import afps_pkg::*;
	logic         clk = 1'b0, rst_n = 1'b0, pd = 1'b0, sb = 1'b0, tg = 1'b0;
	logic         sclk = 1'b0, csb_n = 1'b1, sdi = 1'b0;
	logic         pd_p, sb_p, tg_p, smp, sdo, oe, lock, ready, dclk;
	afps_supply_s sup;
	logic [7:0]   cha, chd, rd;
	logic [3:0]   loe;
	logic [1:0]   bias;
	int           err_count = 0, n_compared = 0, cyc = 0;
	afps_ctrl_model i_afps_ctrl_model (.clk_i(clk), .pd_i(pd), .sb_i(sb), .tg_i(tg), .pd_o(pd_p), .sb_o(sb_p),
		.tg_o(tg_p), .smp_o(smp));
	afps_top i_afps_top (.CLK_I(clk), .RST_N_I(rst_n), .FULL_POWERDOWN_PIN_I(pd_p), .STANDBY_PIN_I(sb_p),
		.TRANSMIT_TRIGGER_I(tg_p), .SAMPLE_CLK_I(smp), .SPI_SCLK_I(sclk), .SPI_CSB_N_I(csb_n), .SPI_SDIO_I(sdi),
		.SPI_SDIO_O(sdo), .SPI_SDIO_OE_O(oe), .SUPPLY_O(sup), .CH_ANALOG_EN_O(cha), .CH_DIGITAL_EN_O(chd),
		.LANE_OE_O(loe), .PREAMP_BIAS_O(bias), .DCS_CLK_O(dclk), .DCS_LOCK_O(lock), .READY_O(ready));
	initial begin
		forever #10 clk = ~clk;
	end
	task test_done;
		$display("mismatches %0d, compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done;
		end
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Serial clock of 160 ns, still outside frames; read data is taken in the high phase
	// A data line that is not driven reads as the inverse, so a late enable shows up
	task spi(input logic rw, input logic [12:0] a, input logic [7:0] d);
		logic [23:0] f;
		f = {rw, 2'b00, a, d};
		csb_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi <= f[i];
			tick(4);
			sclk <= 1'b1;
			tick(2);
			rd = {rd[6:0], oe ? sdo : ~sdo};
			tick(2);
			sclk <= 1'b0;
		end
		sdi <= ~f[0];
		tick(4);
		csb_n <= 1'b1;
		tick(6);
	endtask
	task t_regs;
		spi(1'b1, ADDR_PREAMP_BIAS, 8'h00);
		chk("bias reg", 8'h02, rd); // reset level
		chk("bias pin", 8'h02, {6'h00, bias}); // reset level
		spi(1'b0, ADDR_PREAMP_BIAS, 8'h01);
		spi(1'b1, ADDR_PREAMP_BIAS, 8'h00);
		chk("bias reg", 8'h01, rd); // selectable
		chk("bias pin", 8'h01, {6'h00, bias}); // selectable
		spi(1'b1, 13'h007f, 8'h00);
		chk("unmapped", 8'h00, rd); // empty address
	endtask
	task t_dcs;
		int h = 0;
		chk("lock", 8'h01, {7'h00, lock}); // locked
		repeat (8) begin
			@(posedge clk);
			h += dclk;
		end
		chk("duty", 8'h04, 8'(h)); // half period
		// Stabilizer off: the input's own quarter duty passes through
		spi(1'b0, ADDR_PWR_CTRL, 8'h00);
		h = 0;
		repeat (8) begin
			@(posedge clk);
			h += dclk;
		end
		chk("raw duty", 8'h02, 8'(h)); // stabilizer off
		spi(1'b0, ADDR_PWR_CTRL, PWR_CTRL_RST);
	endtask
	task t_pd;
		int n = 0;
		pd <= 1'b1;
		tick(1000);
		chk("pd supply", 8'h00, {4'h0, sup}); // all off
		chk("pd lanes", 8'h00, {4'h0, loe}); // high impedance
		chk("pd ready", 8'h00, {7'h00, ready}); // powered down
		pd <= 1'b0;
		while (loe == 4'h0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("wake", 8'h01, 8'(n > 940 && n < 1120)); // twenty microseconds
		tick(200);
		chk("ready", 8'h01, {7'h00, ready}); // resumed
		chk("supply", 8'h0f, {4'h0, sup}); // resumed
	endtask
	task t_standby_pin;
		sb <= 1'b1;
		tick(10);
		chk("sb supply", 8'h0c, {4'h0, sup}); // references only
		chk("sb lanes", 8'h00, {4'h0, loe}); // high impedance
		pd <= 1'b1;
		tick(60);
		chk("both", 8'h00, {4'h0, sup}); // power-down wins
		pd <= 1'b0;
		tick(200);
		chk("back sb", 8'h0c, {4'h0, sup}); // into standby
		sb <= 1'b0;
		tick(10);
		chk("sb off", 8'h0f, {4'h0, loe}); // resumed
	endtask
	task t_spi;
		logic [7:0] cfg [3] = '{8'h05, 8'h07, 8'h04};
		logic [7:0] ps [3] = '{8'h0c, 8'h0e, 8'h0f};
		logic [7:0] lo [3] = '{8'h01, 8'h03, 8'h0f};
		for (int i = 0; i < 3; i++) begin
			spi(1'b0, ADDR_LANES, 8'(i));
			spi(1'b0, ADDR_PWR_CTRL, cfg[i]);
			chk("spi supply", ps[i], {4'h0, sup}); // two standby modes, then normal
			chk("spi lanes", cfg[i][PWR_STANDBY_PIN_BIT] ? 8'h00 : lo[i], {4'h0, loe}); // drivers off in standby
			// Standby drops the drivers, so the lane count is judged back in normal mode
			spi(1'b0, ADDR_PWR_CTRL, PWR_CTRL_RST);
			chk("lanes", lo[i], {4'h0, loe}); // lane count
		end
	endtask
	task t_prof;
		int a = 0, d = 0, f = 0, m = 0;
		spi(1'b0, ADDR_START, 8'h04);
		spi(1'b0, ADDR_STOP, 8'h0a);
		spi(1'b0, ADDR_ADVANCE, 8'h02);
		spi(1'b0, ADDR_CH_FULL_POWERDOWN_PIN, 8'hfe);
		chk("unarmed", 8'h00, cha); // before trigger
		tg <= 1'b1;
		for (int n = 0; n < 300; n++) begin
			@(posedge clk);
			tg <= (n < 3);
			if (cha[0] && a == 0) a = n;
			if (chd[0] && d == 0) d = n;
			if (d != 0 && !chd[0] && f == 0) f = n;
			if (cha[7:1] != 7'h00) m = 1;
		end
		chk("start", 8'h01, 8'(a >= 8 && a <= 40)); // from trigger
		chk("advance", 8'h10, 8'(d - a)); // two samples
		chk("run", 8'h30, 8'(f - d)); // six samples
		chk("masked", 8'h00, 8'(m)); // channel power-down
	endtask
	initial begin
		tick(12);
		rst_n <= 1'b1;
		tick(4);
		t_regs;
		t_dcs;
		t_pd;
		t_standby_pin;
		t_spi;
		t_prof;
		test_done;
	end
endmodule // test_afps_top
